// ===== frsr_regs.sv
// Purpose: fault record registers for temperature and rail one, read over the register map
// Assumes: analog detectors deliver asynchronous levels; the serial slave gives offset and a read strobe
// Notes:   clear-on-read flags other than boot stay set through a read while their live condition is present in that cycle
`timescale 1ns/1ns
`include "frsr_params.svh"

// Operation
// - boot event sets bit 7 of the temperature record.
// - boot flag is read-only and clears when the temperature record is read.
// - die warm flag sets above warning threshold, clears on read.
// - overtemp flag sets above shutdown or during recovery, clears on read.
// - power good bit is live: one only inside 90 to 110 percent window.
// - rail one overvoltage flag sets above threshold, clears on read.
// - rail one undervoltage flag sets below threshold or in recovery, clears on read.
// - reserved temperature record bits read zero and have no clear action.
// - host reaches registers by byte reads addressed by register offset.
module frsr_regs
  import frsr_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       boot_event_in,
  input  wire logic       die_warm_in,
  input  wire logic       overtemp_in,
  input  wire logic       overtemp_recovery_in,
  input  wire logic       rail_one_window_in,
  input  wire logic       rail_one_over_in,
  input  wire logic       rail_one_under_in,
  input  wire logic       rail_one_recovery_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_read_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  output logic            boot_event_flag_out,
  output logic            rail_one_power_good_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic       boot_event_flag;
    logic       die_warm_flag;
    logic       overtemp_shutdown_flag;
    logic       rail_one_power_good;
    logic       rail_one_overvoltage_flag;
    logic       rail_one_undervoltage_flag;
    logic       boot_seen;
    frsr_byte_t rdata;
    logic       rvalid;
  } frsr_state_t;

  frsr_state_t st_reg;
  frsr_state_t st_next;
  frsr_cond_t  cond_raw;
  frsr_cond_t  cond;

  // ****************************************
  // input synchronisers
  // ****************************************
  // analog comparators are asynchronous to mclk_in
  assign cond_raw = {boot_event_in, die_warm_in, overtemp_in, overtemp_recovery_in,
                     rail_one_window_in, rail_one_over_in, rail_one_under_in, rail_one_recovery_in};

  frsr_sync #(
    .WIDTH (8)
  ) u_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    (cond_raw),
    .q_out   (cond)
  );

  function automatic frsr_byte_t temp_image(input frsr_state_t s);
    frsr_byte_t b;
    b                  = `FRSR_RESET_BYTE;
    b[`FRSR_BIT_BOOT]  = s.boot_event_flag;
    b[`FRSR_BIT_WARM]  = s.die_warm_flag;
    b[`FRSR_BIT_OTSD]  = s.overtemp_shutdown_flag;
    return b;
  endfunction : temp_image

  function automatic frsr_byte_t rail_image(input frsr_state_t s);
    frsr_byte_t b;
    b                = `FRSR_RESET_BYTE;
    b[`FRSR_BIT_PG]  = s.rail_one_power_good;
    b[`FRSR_BIT_OV]  = s.rail_one_overvoltage_flag;
    b[`FRSR_BIT_UV]  = s.rail_one_undervoltage_flag;
    return b;
  endfunction : rail_image

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic rd_temp;
    logic rd_rail;
    logic boot_edge;
    rd_temp   = reg_read_in && (reg_addr_in == `FRSR_OFS_TEMP);
    rd_rail   = reg_read_in && (reg_addr_in == `FRSR_OFS_RAIL_ONE);
    boot_edge = cond[7] && !st_reg.boot_seen;
    st_next   = st_reg;
    st_next.boot_seen = cond[7];
    st_next.rvalid    = reg_read_in;
    // image captured before clearing, so the read returns the flag that it clears
    if (rd_temp)
    begin
      st_next.rdata = temp_image(st_reg);
    end
    else if (rd_rail)
    begin
      st_next.rdata = rail_image(st_reg);
    end
    else if (reg_read_in)
    begin
      st_next.rdata = `FRSR_RESET_BYTE;
    end
    // clears first, then sets, so a coincident event wins over the read
    if (rd_temp)
    begin
      st_next.boot_event_flag        = 1'b0;
      st_next.die_warm_flag          = 1'b0;
      st_next.overtemp_shutdown_flag = 1'b0;
    end
    if (rd_rail)
    begin
      st_next.rail_one_overvoltage_flag  = 1'b0;
      st_next.rail_one_undervoltage_flag = 1'b0;
    end
    if (boot_edge)
    begin
      st_next.boot_event_flag = 1'b1;
    end
    if (cond[6])
    begin
      st_next.die_warm_flag = 1'b1;
    end
    if (cond[5] || cond[4])
    begin
      st_next.overtemp_shutdown_flag = 1'b1;
    end
    if (cond[2])
    begin
      st_next.rail_one_overvoltage_flag = 1'b1;
    end
    if (cond[1] || cond[0])
    begin
      st_next.rail_one_undervoltage_flag = 1'b1;
    end
    st_next.rail_one_power_good = cond[3];
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata_out           = st_reg.rdata;
  assign reg_rvalid_out          = st_reg.rvalid;
  assign boot_event_flag_out     = st_reg.boot_event_flag;
  assign rail_one_power_good_out = st_reg.rail_one_power_good;

endmodule : frsr_regs

// ===== frsr_params.svh
// Purpose: offsets, field positions and reset values of the fault record registers
// Assumes: byte-wide register map addressed by an 8-bit offset
// Notes:   definitions only
`ifndef FRSR_PARAMS_SVH
`define FRSR_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define FRSR_OFS_TEMP      8'h13
`define FRSR_OFS_RAIL_ONE  8'h14

// ****************************************
// field positions
// ****************************************
`define FRSR_BIT_BOOT      7
`define FRSR_BIT_WARM      2
`define FRSR_BIT_OTSD      1
`define FRSR_BIT_PG        7
`define FRSR_BIT_OV        5
`define FRSR_BIT_UV        4

// ****************************************
// reset values and widths
// ****************************************
`define FRSR_RESET_BYTE    8'h00
`define FRSR_SYNC_STAGES   2

`endif

// ===== frsr_pkg.sv
// Purpose: shared types of the fault record block
// Assumes: nothing
// Notes:   constants live in frsr_params.svh
package frsr_pkg;

  typedef logic [7:0] frsr_byte_t;

  // condition inputs in one vector: boot, warm, otsd, otrec, pg, ov, uv, uvrec
  typedef logic [7:0] frsr_cond_t;

endpackage : frsr_pkg

// ===== frsr_sync.sv
// Purpose: two-stage synchroniser for a vector of asynchronous levels
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module frsr_sync
  import frsr_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } frsr_sync_state_t;

  frsr_sync_state_t st_reg;
  frsr_sync_state_t st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.meta = d_in;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.sync;

endmodule : frsr_sync

// ===== frsr_host_model.sv
// Purpose: host side model issuing byte reads by register offset
// Assumes: one-cycle read strobe, answer one edge later
// Notes:   drives at the falling edge
`timescale 1ns/1ns
module frsr_host_model
  import frsr_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       reg_rvalid_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic            reg_read_out,
  output logic      [7:0] reg_addr_out
);
  // ****************************************
  // byte read
  // ****************************************
  initial
  begin
    reg_read_out = 1'b0;
    reg_addr_out = 8'h00;
  end
  task automatic rd(input logic [7:0] addr, output frsr_byte_t data, output bit ok);
    @(negedge mclk_in);
    reg_read_out = 1'b1;
    reg_addr_out = addr;
    @(negedge mclk_in);
    reg_read_out = 1'b0;
    // released offset shows the inverse, so nothing leans on a stale value
    reg_addr_out = ~addr;
    ok = (reg_rvalid_in === 1'b1);
    data = reg_rdata_in;
  endtask : rd
endmodule : frsr_host_model

// ===== frsr_regs_monitor.sv
// Purpose: port assertions of the fault record block
// Assumes: one clock, synchronous reset held several edges
// Notes:   bound after endmodule
`timescale 1ns/1ns
module frsr_regs_monitor
  import frsr_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic       boot_event_in,
  input wire logic       die_warm_in,
  input wire logic       rail_one_window_in,
  input wire logic       rail_one_over_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic       boot_event_flag_out,
  input wire logic       rail_one_power_good_out
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  chk_read_answered:
    assert property (reg_read_in |=> reg_rvalid_out) else $error("read not answered");
  chk_no_stray:
    assert property (!reg_read_in |=> !reg_rvalid_out) else $error("valid without read");
  chk_data_holds:
    assert property (!reg_rvalid_out |-> $stable(reg_rdata_out)) else $error("read data moved");
  chk_unmapped_zero:
    assert property (reg_read_in && reg_addr_in != 8'h13 && reg_addr_in != 8'h14 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
  chk_temp_reserved:
    assert property (reg_read_in && reg_addr_in == 8'h13 |=> (reg_rdata_out & 8'h79) == 8'h00)
      else $error("reserved bits set");
  chk_boot_image:
    assert property (reg_read_in && reg_addr_in == 8'h13 |=> reg_rdata_out[7] == $past(boot_event_flag_out))
      else $error("boot bit differs from flag");
  chk_boot_clears:
    assert property ((!boot_event_in)[*5] ##0 (reg_read_in && reg_addr_in == 8'h13) |=> !boot_event_flag_out)
      else $error("boot flag not cleared");
  chk_warm_seen:
    assert property (die_warm_in[*4] ##0 (reg_read_in && reg_addr_in == 8'h13) |=> reg_rdata_out[2])
      else $error("warm flag missing");
  chk_ov_rearm:
    assert property (rail_one_over_in[*4] ##0 (reg_read_in && reg_addr_in == 8'h14) |=> reg_rdata_out[5])
      else $error("overvoltage flag missing");
  chk_pg_live:
    assert property ($stable(rail_one_window_in)[*4] |=> rail_one_power_good_out == $past(rail_one_window_in))
      else $error("power good not live");
endmodule : frsr_regs_monitor
bind frsr_regs frsr_regs_monitor mon (.mclk_in(mclk_in), .rst_in(rst_in), .boot_event_in(boot_event_in),
  .die_warm_in(die_warm_in), .rail_one_window_in(rail_one_window_in), .rail_one_over_in(rail_one_over_in),
  .reg_addr_in(reg_addr_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .boot_event_flag_out(boot_event_flag_out),
  .rail_one_power_good_out(rail_one_power_good_out));

// ===== tb_top.sv
// Purpose: directed reads of the fault record registers
// Assumes: conditions settle within four cycles
// Notes:   cond order: boot warm otsd otrec pg ov uv uvrec
`timescale 1ns/1ns
module tb_top
  import frsr_pkg::*;
;
  logic       mclk_in = 1'b0;
  logic       rst_in  = 1'b1;
  frsr_cond_t cond    = 8'h00;
  logic       rd_en, rv, bootf, pg;
  logic [7:0] ad, rdat;
  int         fail_count = 0;
  int         tests_run  = 0;
  // ****************************************
  // harness
  // ****************************************
  initial forever #20 mclk_in = ~mclk_in;
  frsr_host_model host (.mclk_in(mclk_in), .reg_rvalid_in(rv), .reg_rdata_in(rdat), .reg_read_out(rd_en),
    .reg_addr_out(ad));
  frsr_regs dut (.mclk_in(mclk_in), .rst_in(rst_in), .boot_event_in(cond[7]), .die_warm_in(cond[6]),
    .overtemp_in(cond[5]), .overtemp_recovery_in(cond[4]), .rail_one_window_in(cond[3]),
    .rail_one_over_in(cond[2]), .rail_one_under_in(cond[1]), .rail_one_recovery_in(cond[0]),
    .reg_addr_in(ad), .reg_read_in(rd_en), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
    .boot_event_flag_out(bootf), .rail_one_power_good_out(pg));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    frsr_byte_t d;
    bit         ok;
    host.rd(a, d, ok);
    chk("read valid", {7'h00, ok}, 8'h01);
    if (!ok)
      wrap_up();
    chk("read data", d, exp);
  endtask : rd_chk
  // conditions wait four cycles: two sync stages plus the flag edge, with one to spare
  task automatic set_cond(input frsr_cond_t v);
    @(negedge mclk_in);
    cond = v;
    repeat (4) @(negedge mclk_in);
  endtask : set_cond
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    repeat (6) @(negedge mclk_in);
    rst_in = 1'b0;
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h20, 8'h00);
    set_cond(8'he0);
    chk("boot flag", {7'h00, bootf}, 8'h01);
    rd_chk(8'h13, 8'h86);
    rd_chk(8'h13, 8'h06);
    set_cond(8'h1c);
    chk("power good", {7'h00, pg}, 8'h01);
    rd_chk(8'h13, 8'h06);
    rd_chk(8'h13, 8'h02);
    rd_chk(8'h14, 8'ha0);
    set_cond(8'h01);
    rd_chk(8'h14, 8'h30);
    rd_chk(8'h14, 8'h10);
    set_cond(8'h00);
    rd_chk(8'h14, 8'h10);
    rd_chk(8'h14, 8'h00);
    // under threshold alone, without recovery, must also raise the flag
    set_cond(8'h02);
    rd_chk(8'h14, 8'h10);
    set_cond(8'h00);
    rd_chk(8'h14, 8'h10);
    rd_chk(8'h14, 8'h00);
    // mid-run reset must drop a pending flag; condition is gone before release
    set_cond(8'h04);
    @(negedge mclk_in);
    rst_in = 1'b1;
    cond   = 8'h00;
    repeat (3) @(negedge mclk_in);
    rst_in = 1'b0;
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h13, 8'h00);
    wrap_up();
  end
endmodule : tb_top
